// file: rtl/host_port_pkg.sv
package host_port_pkg;

	// ----------------------------------------------------------------
	// Address map of the 128K byte window
	// ----------------------------------------------------------------
	localparam int ADDR_W = 17;
	localparam logic [16:0] VRAM_BYTES = 17'h14000;
	localparam logic [16:0] REG_BASE = 17'h1FFE0;
	localparam int VRAM_WORDS = 40960;
	localparam int REG_WORDS = 16;

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	localparam logic [2:0] GENERIC_SEL = 3'h7;
	localparam logic BS_GENERIC = 1'h0;
	localparam logic ENDIAN_LITTLE = 1'h0;

	// ----------------------------------------------------------------
	// Positions inside the sampled pin vector
	// ----------------------------------------------------------------
	localparam int P_BCLK = 0;
	localparam int P_CS = 1;
	localparam int P_RDLO = 2;
	localparam int P_RDHI = 3;
	localparam int P_WRLO = 4;
	localparam int P_WRHI = 5;
	localparam int P_ADDR = 6;
	localparam int P_DATA = 23;
	localparam int P_SEL = 39;
	localparam int P_ENDIAN = 42;
	localparam int P_BS = 43;
	localparam int PIN_W = 44;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUSY = 2'h1,
		ST_DONE = 2'h3,
		ST_FINISH = 2'h2
	} port_state_e;

endpackage

// file: rtl/display_host_port.sv
// What this block does
// - Straps latched five clocks after reset is released.
// - Endian strap: low little, high big.
// - Select straps high, status low: generic 16-bit.
// - 128K window, 80K buffer at start.
// - Registers fill the last 32 bytes.
// - Upper address ignored, window aliases everywhere.
// - Wait held until data ready or accepted.
`timescale 1ns/1ps
`default_nettype none

module display_host_port (
	input wire logic clk, // System clock, 10 MHz.
	input wire logic rstn, // Controller reset, active low.
	input wire logic bus_clk, // Host bus clock pin.
	input wire logic chip_select_n, // Host chip select.
	input wire logic low_byte_read_n, // Low lane read enable.
	input wire logic high_byte_read_n, // High lane read enable.
	input wire logic low_byte_write_n, // Low lane write enable.
	input wire logic high_byte_write_n, // High lane write enable.
	input wire logic [16:0] host_addr, // Byte address inside the window.
	input wire logic [15:0] host_data_in, // Data bus as seen on the pins.
	input wire logic strap_bit0, // Bus select strap 0.
	input wire logic strap_bit1, // Bus select strap 1.
	input wire logic strap_bit2, // Bus select strap 2.
	input wire logic endian_strap, // Byte order strap.
	input wire logic bus_status_strap_n, // Bus status strap.
	input wire logic refresh_busy, // Display refresh owns the memory.
	output logic [15:0] host_data_out, // Read data driven to the bus.
	output logic host_data_oe, // Data bus drive enable.
	output logic wait_n, // Wait request, active low.
	output logic transfer_ack_n, // Acknowledge, low from wait release until the next bus clock rise.
	output logic transfer_ack_oe, // Acknowledge drive enable.
	output logic big_endian, // Captured byte order.
	output logic generic_mode_ok, // Captured mode is generic 16-bit.
	output logic config_done // Straps have been captured.
);

	typedef struct packed {
		logic [host_port_pkg::PIN_W-1:0] s1;
		logic [host_port_pkg::PIN_W-1:0] s2;
		logic [host_port_pkg::PIN_W-1:0] s3;
		logic [host_port_pkg::PIN_W-1:0] stb;
		logic bclk_last;
		logic [2:0] settle;
		logic done;
		logic big;
		logic mode_ok;
		host_port_pkg::port_state_e state;
		logic [16:0] addr;
		logic [15:0] wdata;
		logic lane_lo;
		logic lane_hi;
		logic is_wr;
		logic [15:0] rdata;
		logic data_oe;
		logic wait_n;
		logic ack_n;
		logic ack_oe;
	} port_s;

	port_s q;
	port_s d;
	logic [15:0] vram [0:host_port_pkg::VRAM_WORDS-1];
	logic [15:0] regs [0:host_port_pkg::REG_WORDS-1];
	logic [host_port_pkg::PIN_W-1:0] pins;
	logic [host_port_pkg::PIN_W-1:0] agree;
	logic rise;
	logic cs_on;
	logic rd_lo;
	logic rd_hi;
	logic wr_lo;
	logic wr_hi;
	logic in_vram;
	logic in_regs;
	logic [15:0] word_rd;
	logic mem_we;

	assign pins = {bus_status_strap_n, endian_strap, strap_bit2, strap_bit1, strap_bit0,
		host_data_in, host_addr, high_byte_write_n, low_byte_write_n,
		high_byte_read_n, low_byte_read_n, chip_select_n, bus_clk};

	// ----------------------------------------------------------------
	// Window decode and memory read
	// ----------------------------------------------------------------
	assign in_vram = q.addr < host_port_pkg::VRAM_BYTES;
	assign in_regs = q.addr >= host_port_pkg::REG_BASE;
	assign word_rd = in_vram ? vram[q.addr[16:1]] : (in_regs ? regs[q.addr[4:1]] : 16'h0000);
	assign mem_we = (q.state == host_port_pkg::ST_BUSY) && !refresh_busy && q.is_wr;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// A bit moves only once the second and third stages agree.
		agree = ~(q.s2 ^ q.s3);
		d.stb = (q.s2 & agree) | (q.stb & ~agree);
		d.bclk_last = q.stb[host_port_pkg::P_BCLK];
		rise = q.stb[host_port_pkg::P_BCLK] & ~q.bclk_last;
		cs_on = ~q.stb[host_port_pkg::P_CS];
		rd_lo = ~q.stb[host_port_pkg::P_RDLO];
		rd_hi = ~q.stb[host_port_pkg::P_RDHI];
		wr_lo = ~q.stb[host_port_pkg::P_WRLO];
		wr_hi = ~q.stb[host_port_pkg::P_WRHI];
		// The sampler needs a few cycles to fill before straps are trusted.
		if (!q.done)
		begin
			if (q.settle == host_port_pkg::STRAP_SETTLE)
			begin
				d.done = 1'b1;
				d.big = q.stb[host_port_pkg::P_ENDIAN] != host_port_pkg::ENDIAN_LITTLE;
				d.mode_ok = (q.stb[host_port_pkg::P_ENDIAN-1:host_port_pkg::P_SEL] ==
					host_port_pkg::GENERIC_SEL) &&
					(q.stb[host_port_pkg::P_BS] == host_port_pkg::BS_GENERIC);
			end
			else
			begin
				d.settle = q.settle + 3'h1;
			end
		end
		case (q.state)
			host_port_pkg::ST_IDLE:
			begin
				if (q.done && q.mode_ok && rise && cs_on && (rd_lo | rd_hi | wr_lo | wr_hi))
				begin
					// Only 17 address bits exist, so the window repeats upward.
					d.addr = q.stb[host_port_pkg::P_DATA-1:host_port_pkg::P_ADDR];
					d.wdata = q.stb[host_port_pkg::P_SEL-1:host_port_pkg::P_DATA];
					if (q.big)
					begin
						d.wdata = {d.wdata[7:0], d.wdata[15:8]};
					end
					d.is_wr = wr_lo | wr_hi;
					d.lane_lo = q.big ? (wr_hi | rd_hi) : (wr_lo | rd_lo);
					d.lane_hi = q.big ? (wr_lo | rd_lo) : (wr_hi | rd_hi);
					d.wait_n = 1'b0;
					d.ack_n = 1'b1;
					d.ack_oe = 1'b1;
					d.state = host_port_pkg::ST_BUSY;
				end
			end
			host_port_pkg::ST_BUSY:
			begin
				// Refresh has priority; the host keeps waiting meanwhile.
				if (!refresh_busy)
				begin
					if (!q.is_wr)
					begin
						d.rdata = q.big ? {word_rd[7:0], word_rd[15:8]} : word_rd;
					end
					d.data_oe = ~q.is_wr;
					d.wait_n = 1'b1;
					d.ack_n = 1'b0;
					d.state = host_port_pkg::ST_DONE;
				end
			end
			host_port_pkg::ST_DONE:
			begin
				if (rise)
				begin
					d.ack_n = 1'b1;
					d.state = host_port_pkg::ST_FINISH;
				end
			end
			host_port_pkg::ST_FINISH:
			begin
				if (!cs_on || !(rd_lo | rd_hi | wr_lo | wr_hi))
				begin
					d.data_oe = 1'b0;
					d.ack_oe = 1'b0;
					d.state = host_port_pkg::ST_IDLE;
				end
			end
			default:
			begin
				d.state = host_port_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.state <= host_port_pkg::ST_IDLE;
			q.wait_n <= 1'b1;
			q.ack_n <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Display buffer and register storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (mem_we && in_vram)
		begin
			if (q.lane_lo)
			begin
				vram[q.addr[16:1]][7:0] <= q.wdata[7:0];
			end
			if (q.lane_hi)
			begin
				vram[q.addr[16:1]][15:8] <= q.wdata[15:8];
			end
		end
		else if (mem_we && in_regs)
		begin
			if (q.lane_lo)
			begin
				regs[q.addr[4:1]][7:0] <= q.wdata[7:0];
			end
			if (q.lane_hi)
			begin
				regs[q.addr[4:1]][15:8] <= q.wdata[15:8];
			end
		end
	end

	assign host_data_out = q.rdata;
	assign host_data_oe = q.data_oe;
	assign wait_n = q.wait_n;
	assign transfer_ack_n = q.ack_n;
	assign transfer_ack_oe = q.ack_oe;
	assign big_endian = q.big;
	assign generic_mode_ok = q.mode_ok;
	assign config_done = q.done;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_strap_capture: assert property ($rose(q.done)
		|-> q.big == $past(q.stb[host_port_pkg::P_ENDIAN]))
		else $error("endian strap not captured at release");
	a_no_early_access: assert property (!q.done |-> q.state == host_port_pkg::ST_IDLE)
		else $error("access accepted before straps captured");
	a_mode_gate: assert property (!q.mode_ok |-> q.wait_n && !q.ack_oe)
		else $error("access accepted outside generic mode");
	a_swap_read: assert property ((q.state == host_port_pkg::ST_BUSY && !refresh_busy && !q.is_wr && q.big)
		|=> q.rdata == {$past(word_rd[7:0]), $past(word_rd[15:8])})
		else $error("big endian read not byte swapped");
	a_vram_write: assert property ((mem_we && in_vram && q.lane_lo && q.lane_hi)
		|=> vram[$past(q.addr[16:1])] == $past(q.wdata))
		else $error("display buffer write lost");
	a_gap_zero: assert property ((q.state == host_port_pkg::ST_BUSY && !refresh_busy && !q.is_wr
		&& !in_vram && !in_regs) |=> q.rdata == 16'h0000)
		else $error("unmapped gap read not zero");
	a_wait_held: assert property ((q.state == host_port_pkg::ST_BUSY && refresh_busy) |=> !q.wait_n)
		else $error("wait released during refresh");
	a_ack_with_wait: assert property ($rose(q.wait_n) |-> !q.ack_n && q.ack_oe)
		else $error("acknowledge not active with wait release");
	a_ack_selected: assert property (!q.ack_n |-> q.ack_oe && q.state == host_port_pkg::ST_DONE)
		else $error("acknowledge outside selected access");

	c_read: cover property (q.state == host_port_pkg::ST_DONE && q.data_oe);
	c_write: cover property (mem_we && in_vram);
	c_refresh_stall: cover property (q.state == host_port_pkg::ST_BUSY && refresh_busy [*3]);
	c_reg_access: cover property (mem_we && in_regs);

endmodule

`default_nettype wire

// file: verif/host_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host master: one strobe access per call, free running bus clock.
// ----------------------------------------------------------------
module host_master (
	input wire logic clk, // System clock.
	input wire logic ack_n, // Acknowledge line as the host sees it.
	input wire logic wait_n, // Wait request.
	input wire logic [15:0] din, // Data line as the host sees it.
	output logic bus_clk, // Host bus clock.
	output logic cs_n, // Chip select.
	output logic [3:0] stb_n, // Write hi, write lo, read hi, read lo.
	output logic [16:0] addr, // Byte address.
	output logic [15:0] dout // Write data; inverted when not writing.
);
	// ----------------------------------------------------------------
	// Chip-select programming of the processor for this port
	// ----------------------------------------------------------------
	// The port sits on one of the fixed 2M I/O selects; its block index is an arbitrary placement.
	localparam logic [2:0] select_block = 3'h4;
	// Upper 8 bits of the port's base address; the value is an arbitrary placement.
	localparam logic [7:0] select_base_reg = 8'h40;
	localparam logic write_protect_bit = 1'h0;
	localparam logic alt_master_bit = 1'h0;
	localparam logic select_valid_bit = 1'h1;
	// The model makes data cycles only, so code and CPU-space cycles never reach the port.
	localparam logic cpu_space_bit = 1'h1;
	localparam logic super_code_bit = 1'h1;
	localparam logic user_code_bit = 1'h1;
	localparam logic super_data_bit = 1'h0;
	localparam logic user_data_bit = 1'h0;
	localparam logic [3:0] internal_wait_count = 4'h0;
	localparam logic auto_ack_bit = 1'h0;
	localparam logic [1:0] port_size_field = 2'h2;
	localparam logic byte_enable_mode_bit = 1'h0;
	// The model runs single beats only, so it stays off the port if bursts were on.
	localparam logic burst_read_bit = 1'h0;
	localparam logic burst_write_bit = 1'h0;
	// A 16-bit port has two byte lanes.
	localparam logic [1:0] lane_mask = (port_size_field == 2'h2) ? 2'h3 : 2'h1;

	// Processor address of an offset in the port's 2M block, or of a block elsewhere.
	function automatic logic [31:0] cpu_addr(input logic hit, input logic [20:0] off);
		return {hit ? select_base_reg : ~select_base_reg, select_block, off};
	endfunction

	initial
	begin
		cs_n = 1'b1;
		stb_n = 4'hF;
		addr = 17'h00000;
		dout = 16'h0000;
		bus_clk = 1'b0;
		forever #400 bus_clk = ~bus_clk;
	end

	task automatic access(input logic wr, input logic [31:0] a, input logic [1:0] ln,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		logic pw;
		logic seen;
		logic sel;
		logic priv;
		int i;
		pw = 1'b1;
		seen = 1'b0;
		ok = 1'b0;
		@(posedge bus_clk);
		@(posedge clk);
		priv = 1'($urandom);
		sel = a[31:24] == select_base_reg && a[23:21] == select_block && select_valid_bit
			&& !(wr && write_protect_bit) && !(priv ? super_data_bit : user_data_bit)
			&& !(wr ? burst_write_bit : burst_read_bit);
		cs_n <= !sel;
		// Upper block lines are not wired, so the window repeats across the block.
		addr <= a[16:0];
		dout <= wr ? wd : ~dout;
		stb_n <= wr ? {~(ln & lane_mask), 2'h3}
			: {2'h3, byte_enable_mode_bit ? ~(ln & lane_mask) : ~lane_mask};
		for (i = 0; i < 60 && !seen; i++)
		begin
			@(posedge clk);
			seen = ack_n === 1'b0 || (auto_ack_bit && i >= int'(internal_wait_count));
			if (seen)
				ok = pw === 1'b0 && wait_n === 1'b1;
			pw = wait_n;
		end
		rd = din;
		// The host holds the cycle until the next rising edge of the bus clock.
		if (seen)
			@(posedge bus_clk);
		@(posedge clk);
		cs_n <= 1'b1;
		stb_n <= 4'hF;
		dout <= ~dout;
		// No new cycle may start while the acknowledge is still low.
		for (i = 0; i < 60 && ack_n === 1'b0; i++)
			@(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic clk, rstn, refresh_busy, bus_clk, cs_n, ok, data_oe, wait_n, ack_n, ack_oe;
	logic big_endian, generic_ok, cfg_done, ack_line;
	logic [4:0] straps;
	logic [3:0] stb_n;
	logic [16:0] addr, a;
	logic [15:0] dout, rdata, rd, wd, data_line;
	logic [15:0] mem [int];
	int fail_count, num_checks;

	// An unselected device leaves the acknowledge to the pull-up.
	assign ack_line = ack_oe ? ack_n : 1'b1;
	assign data_line = data_oe ? rdata : dout;

	display_host_port DUT (.clk(clk), .rstn(rstn), .bus_clk(bus_clk), .chip_select_n(cs_n),
		.low_byte_read_n(stb_n[0]), .high_byte_read_n(stb_n[1]), .low_byte_write_n(stb_n[2]),
		.high_byte_write_n(stb_n[3]), .host_addr(addr), .host_data_in(dout),
		.strap_bit0(straps[0]), .strap_bit1(straps[1]), .strap_bit2(straps[2]),
		.endian_strap(straps[3]), .bus_status_strap_n(straps[4]), .refresh_busy(refresh_busy),
		.host_data_out(rdata), .host_data_oe(data_oe), .wait_n(wait_n), .transfer_ack_n(ack_n),
		.transfer_ack_oe(ack_oe), .big_endian(big_endian), .generic_mode_ok(generic_ok),
		.config_done(cfg_done));
	host_master host (.clk(clk), .ack_n(ack_line), .wait_n(wait_n), .din(data_line),
		.bus_clk(bus_clk), .cs_n(cs_n), .stb_n(stb_n), .addr(addr), .dout(dout));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
		refresh_busy <= ($urandom % 6) == 0;

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
		input logic [1:0] ln);
		return {ln[1] ? n[15:8] : o[15:8], ln[0] ? n[7:0] : o[7:0]};
	endfunction

	function automatic logic [16:0] pick(input int i);
		logic [16:0] c [4] = '{17'h13FFE, 17'h1FFFE, 17'h14000, 17'h1FFDF};
		if (i < 4)
			return c[i];
		case ($urandom % 3)
			0: return 17'($urandom_range(0, 17'h13FFF));
			1: return 17'h1FFE0 + 17'($urandom_range(0, 31));
			default: return 17'($urandom_range(17'h14000, 17'h1FFDF));
		endcase
	endfunction

	task automatic start(input logic [4:0] s);
		@(posedge clk);
		rstn <= 1'b0;
		straps <= s;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
		`CHK("config_done", 1'b1, cfg_done)
		`CHK("big_endian", s[3], big_endian)
		`CHK("generic_mode_ok", s[2:0] == 3'h7 && !s[4], generic_ok)
	endtask

	task automatic xfer(input logic wr, input logic [16:0] x, input logic [1:0] ln);
		int k;
		k = int'(x[16:1]);
		wd = 16'($urandom);
		host.access(wr, host.cpu_addr(1'b1, {4'($urandom), x}), ln, wd, rd, ok);
		`CHK("ack", 1'b1, ok)
		// Only the buffer and the register block keep what is written.
		if (wr && (x < host_port_pkg::VRAM_BYTES || x >= host_port_pkg::REG_BASE))
			mem[k] = merge(mem.exists(k) ? mem[k] : 16'h0000, wd, ln);
		if (!wr)
			`CHK("rdata", mem.exists(k) ? mem[k] : 16'h0000, rd)
		repeat (8) @(posedge clk);
		`CHK("ack_oe", 1'b0, ack_oe)
		`CHK("data_oe", 1'b0, data_oe)
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		rstn = 1'b0;
		refresh_busy = 1'b0;
		straps = 5'h07;
		fail_count = 0;
		num_checks = 0;
		void'($urandom(32'hD8B3D014));
		for (int t = 0; t < 6; t++)
		begin
			straps <= t < 2 ? {1'b0, t[0], 3'h7} : (t == 2 ? 5'h17 : 5'($urandom));
			@(posedge clk);
			start(straps);
			if (straps[2:0] != 3'h7 || straps[4])
			begin
				host.access(1'b0, host.cpu_addr(1'b1, 21'h00000), 2'h3, 16'h0000, rd, ok);
				`CHK("refused", 1'b0, ok)
			end
		end
		$display("strap test done");
		for (int e = 1; e >= 0; e--)
		begin
			start({1'b0, e[0], 3'h7});
			host.access(1'b0, host.cpu_addr(1'b0, 21'h00000), 2'h3, 16'h0000, rd, ok);
			`CHK("deselected", 1'b0, ok)
			if (e == 0)
			begin
				// Words stored big endian come back byte swapped in little endian.
				foreach (mem[j])
					mem[j] = {mem[j][7:0], mem[j][15:8]};
				xfer(1'b0, 17'h13FFE, 2'h3);
				xfer(1'b0, 17'h1FFFE, 2'h3);
			end
			else
				mem.delete();
			for (int i = 0; i < 25; i++)
			begin
				a = pick(i);
				xfer(1'b1, a, 2'h3);
				xfer(1'b1, a, 2'($urandom_range(1, 2)));
				xfer(1'b0, a, 2'h3);
			end
			$display("traffic test done, big endian %0d", e);
		end
		print_verdict();
	end

	initial
	begin
		#2000000;
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
